// file: design/gcr_map.vh
`ifndef GCR_MAP_VH
`define GCR_MAP_VH

// ----------------------------------------------------------------------------
// Register word indices (byte address is index times four)
// ----------------------------------------------------------------------------
`define GCR_IDX_ANALOG_DIAG    8'h0C
`define GCR_IDX_CHIP_ID        8'h0D
`define GCR_IDX_SOFT_RESET     8'h0E
`define GCR_IDX_PATTERN_CTRL   8'h0F
`define GCR_IDX_DECODER_CFG    8'h10
`define GCR_IDX_MODE_CTRL      8'h11
`define GCR_IDX_DECODER_STAT   8'h12
`define GCR_IDX_MASTER_DIAG    8'h0A

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GCR_ANALOG_MASK        8'h33
`define GCR_DEC_MASK           8'hE7
`define GCR_DEC_LINE_CODE      7
`define GCR_DEC_LOS_HI         6
`define GCR_DEC_LOS_LO         5
`define GCR_DEC_ALG            2
`define GCR_DEC_VIOL           1
`define GCR_PAT_PAIR3          7
`define GCR_PAT_PAIR2          6
`define GCR_PAT_PAIR1          5
`define GCR_PAT_GAP_GEN        4
`define GCR_PAT_GAP_DET        3
`define GCR_PAT_RX_GEN         2
`define GCR_PAT_UNFRAMED_GENERATION        1
`define GCR_PAT_UNFRAMED_DETECTION        0
`define GCR_MODE_E1            0
`define GCR_MODE_SINGLE_RAIL   1
`define GCR_MODE_NEW_REV       2
`define GCR_MODE_SIG_DIS       3
`define GCR_MODE_FRM_DIS       4

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define GCR_RST_BYTE           8'h00
// Type and version codes are arbitrary
`define GCR_TYPE_CODE          3'h5
`define GCR_VERSION_CODE       5'h0A
`define GCR_BITS_T1            9'h0C1
`define GCR_BITS_E1            9'h100
`define GCR_BITS_GAPPED        4'h7
`define GCR_BITS_SLOT          4'h8
`define GCR_LOS_E1_HDB3        8'h0A
`define GCR_LOS_T1_AMI         8'h0F
`define GCR_LOS_CODE1          8'h1F
`define GCR_LOS_CODE2          8'h3F
`define GCR_LOS_CODE3          8'hAF
`define GCR_RESP_OKAY          2'h0
`define GCR_RESP_SLVERR        2'h2

`endif

// file: design/gcr_global_control.v
// Function
// - Identity register reads fixed three-bit type and five-bit version.
// - Any identity write pulses a simultaneous counter update.
// - Newer revision drives master diagnostics bit 6 high; older returns held bus value.
// - Software reset bit holds the device reset until software writes zero.
// - Hardware reset clears the software reset bit.
// - Bits 7,6,5 stop clocks of link pairs three, two, one.
// - Gapped generation fills only first seven bits of each selected slot.
// - Gapped detection checks only first seven bits of each selected slot.
// - Placement bit puts generator in receive path, detector in transmit path.
// - Unframed generation overwrites all 193 or 256 bits per frame.
// - Transmit unframed generation keeps signaling and framing unless disabled.
// - Receive unframed generation also replaces framing bit positions.
// - Unframed generation overrides per-slot generation and gapped generation.
// - Transmit unframed generation overrides idle code and data inversion.
// - Unframed detection covers whole frame, overriding per-slot and gapped detection.
// - Decoder configuration held at reset value while in single-rail mode.
// - E1 HDB3, select zero: flag stray violations and same-polarity signatures.
// - E1 HDB3, select one: flag only same-polarity bipolar violations.
// - Violation select ignored in T1 and under AMI coding.
// - Line code bit picks AMI, else HDB3 in E1 or B8ZS in T1.
// - Loss threshold select gives 10/15, 31, 63 or 175 zeros.
module gcr_global_control (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Decoder line events
  input  wire        lineMark,
  input  wire        linePolarity,
  input  wire        lineBitStrobe,
  input  wire        inSignature,
  // Pattern slot position
  input  wire [2:0]  slotBitIndex,
  input  wire        slotSelected,
  input  wire        frameBitStrobe,
  input  wire        framingBitPos,
  input  wire        signalingBitPos,
  // Block controls
  output reg         counterUpdate,
  output reg         functionResetN,
  output reg         linkPair1ClockOn,
  output reg         linkPair2ClockOn,
  output reg         linkPair3ClockOn,
  output reg         generatorInReceivePath,
  output reg         generatorActive,
  output reg         detectorActive,
  output reg         txOverrideIdleInvert,
  output reg         decoderAmi,
  output reg         decoderAlgorithm,
  output reg  [7:0]  lossThreshold,
  output reg         lineViolation,
  output reg         signalLoss
);

  // --------------------------------------------------------------------------
  // Registers and decode
  // --------------------------------------------------------------------------
  `include "gcr_map.vh"

  reg  [7:0] analogDiag;
  reg        softReset;
  reg  [7:0] patternCtrl;
  reg  [7:0] decoderCfg;
  reg  [4:0] modeCtrl;
  reg  [8:0] frameBitCount;
  reg  [7:0] zeroRun;
  reg        lastViolPol;
  reg        lastMarkPol;
  reg        bitSync1;
  reg        bitSync2;
  reg        bitSync3;
  reg        markSync1;
  reg        markSync2;
  reg        polSync1;
  reg        polSync2;
  reg        sigSync1;
  reg        sigSync2;
  reg        readHold6;

  wire [5:0] wrIndex = s_axi_awaddr[7:2];
  wire [5:0] rdIndex = s_axi_araddr[7:2];
  wire       doWrite = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire       doRead  = s_axi_arvalid & ~s_axi_rvalid;
  wire       wrLane0 = s_axi_wstrb[0];
  wire [7:0] wrByte  = s_axi_wdata[7:0];
  wire       e1Mode  = modeCtrl[`GCR_MODE_E1];
  wire       singleRail = modeCtrl[`GCR_MODE_SINGLE_RAIL];
  wire [7:0] idByte     = {`GCR_TYPE_CODE, `GCR_VERSION_CODE};

  assign s_axi_awready = doWrite;
  assign s_axi_wready  = doWrite;
  assign s_axi_arready = doRead;

  function hit;
    input [5:0] index;
    input [7:0] regIndex;
    begin
      hit = (index == regIndex[5:0]);
    end
  endfunction

  function known;
    input [5:0] index;
    begin
      known = hit(index, `GCR_IDX_ANALOG_DIAG) | hit(index, `GCR_IDX_CHIP_ID) |
              hit(index, `GCR_IDX_SOFT_RESET) | hit(index, `GCR_IDX_PATTERN_CTRL) |
              hit(index, `GCR_IDX_DECODER_CFG) | hit(index, `GCR_IDX_MODE_CTRL) |
              hit(index, `GCR_IDX_DECODER_STAT) | hit(index, `GCR_IDX_MASTER_DIAG);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      analogDiag    <= `GCR_RST_BYTE;
      softReset     <= 1'b0;
      patternCtrl   <= `GCR_RST_BYTE;
      decoderCfg    <= `GCR_RST_BYTE;
      modeCtrl      <= 5'h00;
      counterUpdate <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `GCR_RESP_OKAY;
    end else begin
      counterUpdate <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known(wrIndex) ? `GCR_RESP_OKAY : `GCR_RESP_SLVERR;
        if (hit(wrIndex, `GCR_IDX_CHIP_ID)) begin
          counterUpdate <= 1'b1;
        end
        if (wrLane0) begin
          if (hit(wrIndex, `GCR_IDX_SOFT_RESET)) begin
            softReset <= wrByte[0];
          end
          if (softReset == 1'b0) begin
            if (hit(wrIndex, `GCR_IDX_ANALOG_DIAG)) begin
              analogDiag <= wrByte & `GCR_ANALOG_MASK;
            end
            if (hit(wrIndex, `GCR_IDX_PATTERN_CTRL)) begin
              patternCtrl <= wrByte;
            end
            if (hit(wrIndex, `GCR_IDX_DECODER_CFG)) begin
              decoderCfg <= wrByte & `GCR_DEC_MASK;
            end
            if (hit(wrIndex, `GCR_IDX_MODE_CTRL)) begin
              modeCtrl <= wrByte[4:0];
            end
          end
        end
      end
      if (softReset) begin
        analogDiag  <= `GCR_RST_BYTE;
        patternCtrl <= `GCR_RST_BYTE;
        decoderCfg  <= `GCR_RST_BYTE;
        modeCtrl    <= 5'h00;
      end
      if (singleRail) begin
        decoderCfg <= `GCR_RST_BYTE;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `GCR_RESP_OKAY;
      readHold6    <= 1'b0;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= known(rdIndex) ? `GCR_RESP_OKAY : `GCR_RESP_SLVERR;
        s_axi_rdata  <= 32'h0000_0000;
        if (hit(rdIndex, `GCR_IDX_ANALOG_DIAG)) begin
          s_axi_rdata[7:0] <= analogDiag;
        end
        if (hit(rdIndex, `GCR_IDX_CHIP_ID)) begin
          s_axi_rdata[7:0] <= idByte;
          readHold6        <= idByte[6];
        end
        if (hit(rdIndex, `GCR_IDX_SOFT_RESET)) begin
          s_axi_rdata[0] <= softReset;
        end
        if (hit(rdIndex, `GCR_IDX_PATTERN_CTRL)) begin
          s_axi_rdata[7:0] <= patternCtrl;
        end
        if (hit(rdIndex, `GCR_IDX_DECODER_CFG)) begin
          s_axi_rdata[7:0] <= decoderCfg;
        end
        if (hit(rdIndex, `GCR_IDX_MODE_CTRL)) begin
          s_axi_rdata[4:0] <= modeCtrl;
        end
        if (hit(rdIndex, `GCR_IDX_DECODER_STAT)) begin
          s_axi_rdata[1:0] <= {lineViolation, signalLoss};
        end
        if (hit(rdIndex, `GCR_IDX_MASTER_DIAG)) begin
          s_axi_rdata[6] <= modeCtrl[`GCR_MODE_NEW_REV] ? 1'b1 : readHold6;
        end
        if (!hit(rdIndex, `GCR_IDX_CHIP_ID)) begin
          readHold6 <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Clock gating and pattern routing
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      functionResetN         <= 1'b0;
      linkPair1ClockOn       <= 1'b0;
      linkPair2ClockOn       <= 1'b0;
      linkPair3ClockOn       <= 1'b0;
      generatorInReceivePath <= 1'b0;
      txOverrideIdleInvert   <= 1'b0;
      decoderAmi             <= 1'b0;
      decoderAlgorithm       <= 1'b0;
      lossThreshold          <= `GCR_LOS_E1_HDB3;
    end else begin
      functionResetN         <= ~softReset;
      linkPair3ClockOn       <= ~patternCtrl[`GCR_PAT_PAIR3] & ~softReset;
      linkPair2ClockOn       <= ~patternCtrl[`GCR_PAT_PAIR2] & ~softReset;
      linkPair1ClockOn       <= ~patternCtrl[`GCR_PAT_PAIR1] & ~softReset;
      generatorInReceivePath <= patternCtrl[`GCR_PAT_RX_GEN];
      txOverrideIdleInvert   <= patternCtrl[`GCR_PAT_UNFRAMED_GENERATION] &
                                ~patternCtrl[`GCR_PAT_RX_GEN];
      decoderAmi             <= decoderCfg[`GCR_DEC_LINE_CODE];
      decoderAlgorithm       <= decoderCfg[`GCR_DEC_ALG];
      case (decoderCfg[`GCR_DEC_LOS_HI:`GCR_DEC_LOS_LO])
        2'b01:   lossThreshold <= `GCR_LOS_CODE1;
        2'b10:   lossThreshold <= `GCR_LOS_CODE2;
        2'b11:   lossThreshold <= `GCR_LOS_CODE3;
        default: lossThreshold <= (e1Mode && !decoderCfg[`GCR_DEC_LINE_CODE]) ?
                                  `GCR_LOS_E1_HDB3 : `GCR_LOS_T1_AMI;
      endcase
    end
  end

  // Frame position for unframed coverage
  wire [8:0] frameLen  = e1Mode ? `GCR_BITS_E1 : `GCR_BITS_T1;
  wire       gappedBit = ({1'b0, slotBitIndex} + 4'h1) > `GCR_BITS_GAPPED;
  wire       slotOkGen = slotSelected &
                         ~(patternCtrl[`GCR_PAT_GAP_GEN] & gappedBit);
  wire       slotOkDet = slotSelected &
                         ~(patternCtrl[`GCR_PAT_GAP_DET] & gappedBit);
  wire       txKeeps   = (signalingBitPos & ~modeCtrl[`GCR_MODE_SIG_DIS]) |
                         (framingBitPos & ~modeCtrl[`GCR_MODE_FRM_DIS]);

  always @(posedge clk) begin
    if (!rstn) begin
      frameBitCount   <= 9'h000;
      generatorActive <= 1'b0;
      detectorActive  <= 1'b0;
    end else begin
      if (frameBitStrobe) begin
        frameBitCount <= (frameBitCount + 9'h001 >= frameLen) ? 9'h000 :
                         frameBitCount + 9'h001;
      end
      if (patternCtrl[`GCR_PAT_UNFRAMED_GENERATION]) begin
        generatorActive <= patternCtrl[`GCR_PAT_RX_GEN] ? 1'b1 : ~txKeeps;
      end else begin
        generatorActive <= slotOkGen;
      end
      detectorActive <= patternCtrl[`GCR_PAT_UNFRAMED_DETECTION] ? 1'b1 : slotOkDet;
    end
  end

  // --------------------------------------------------------------------------
  // Line violation and loss of signal
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      bitSync1  <= 1'b0;
      bitSync2  <= 1'b0;
      bitSync3  <= 1'b0;
      markSync1 <= 1'b0;
      markSync2 <= 1'b0;
      polSync1  <= 1'b0;
      polSync2  <= 1'b0;
      sigSync1  <= 1'b0;
      sigSync2  <= 1'b0;
    end else begin
      bitSync1  <= lineBitStrobe;
      bitSync2  <= bitSync1;
      bitSync3  <= bitSync2;
      markSync1 <= lineMark;
      markSync2 <= markSync1;
      polSync1  <= linePolarity;
      polSync2  <= polSync1;
      sigSync1  <= inSignature;
      sigSync2  <= sigSync1;
    end
  end

  wire bitTick   = bitSync2 & ~bitSync3;
  wire bipolar   = markSync2 & (polSync2 == lastMarkPol);
  wire samePol   = bipolar & (polSync2 == lastViolPol);
  wire useViolSel = e1Mode & ~decoderCfg[`GCR_DEC_LINE_CODE];
  wire hdb3Viol  = decoderCfg[`GCR_DEC_VIOL] ? samePol :
                   (bipolar & ~sigSync2) | (bipolar & sigSync2 & samePol);
  wire plainViol = bipolar & ~sigSync2;

  always @(posedge clk) begin
    if (!rstn || !functionResetN) begin
      zeroRun       <= 8'h00;
      lastViolPol   <= 1'b0;
      lastMarkPol   <= 1'b0;
      lineViolation <= 1'b0;
      signalLoss    <= 1'b0;
    end else if (bitTick) begin
      lineViolation <= useViolSel ? hdb3Viol : plainViol;
      if (markSync2) begin
        lastMarkPol <= polSync2;
        zeroRun     <= 8'h00;
        signalLoss  <= 1'b0;
      end else begin
        if (zeroRun != 8'hFF) begin
          zeroRun <= zeroRun + 8'h01;
        end
        if (zeroRun >= lossThreshold) begin
          signalLoss <= 1'b1;
        end
      end
      if (bipolar) begin
        lastViolPol <= polSync2;
      end
    end else begin
      lineViolation <= 1'b0;
    end
  end

endmodule

// file: tb/gcr_global_control_props.sv
`include "gcr_map.vh"
// ----
// Bus and control checks
// ----
module gcr_props (
  // Clock and reset
  input wire        clk,
  input wire        rstn,
  // Write channels
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // Read channels
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Controls
  input wire        counterUpdate,
  input wire        functionResetN,
  input wire        linkPair1ClockOn,
  input wire        linkPair2ClockOn,
  input wire        linkPair3ClockOn,
  input wire [7:0]  lossThreshold
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid;
  wire idWr   = wrTake && s_axi_awaddr[7:2] == 6'h0D;
  wire srWr   = wrTake && s_axi_awaddr[7:2] == 6'h0E && s_axi_wstrb[0];
  wire rdTake = s_axi_arvalid && s_axi_arready;
  wire anyOn  = linkPair1ClockOn || linkPair2ClockOn || linkPair3ClockOn;

  AST_WR_RESP: assert property (wrTake |=> s_axi_bvalid)
    else $error("write response missing");
  AST_RD_RESP: assert property (rdTake |=> s_axi_rvalid)
    else $error("read response missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_CNT_UPD: assert property (
    idWr && functionResetN |=> counterUpdate ##1 !counterUpdate) else $error("no update pulse");
  AST_CNT_CAUSE: assert property (counterUpdate |-> $past(idWr))
    else $error("stray update pulse");
  AST_ID_READ: assert property (rdTake && s_axi_araddr == 8'h34
    |=> s_axi_rdata == {24'h0, `GCR_TYPE_CODE, `GCR_VERSION_CODE}) else $error("bad identity");
  AST_SR_SET: assert property (srWr && s_axi_wdata[0] |-> ##[1:3] !functionResetN)
    else $error("soft reset not applied");
  AST_SR_HOLD: assert property (
    !functionResetN && $past(rstn) && $past(rstn, 2) && !srWr && !$past(srWr)
    && !$past(srWr, 2) |=> !functionResetN) else $error("soft reset self cleared");
  AST_PAIR_OFF: assert property ($fell(functionResetN) |-> ##[0:2] !anyOn)
    else $error("link clock left on");
  AST_THRESH: assert property (
    lossThreshold inside {8'h0A, 8'h0F, 8'h1F, 8'h3F, 8'hAF}) else $error("bad threshold");

  cover property (counterUpdate);
  cover property ($fell(functionResetN));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// file: tb/gcr_global_control_tb.sv
`include "gcr_map.vh"
module gcr_global_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Stimulus and model state
  // ----
  logic        clk = 0, rstn = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        lineMark = 0, linePolarity = 0, lineBitStrobe = 0, inSignature = 0;
  logic [2:0]  slotBitIndex = 0;
  logic        slotSelected = 0, frameBitStrobe = 0, framingBitPos = 0, signalingBitPos = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [7:0]  lossThreshold;
  wire         counterUpdate, functionResetN, linkPair1ClockOn, linkPair2ClockOn;
  wire         linkPair3ClockOn, generatorInReceivePath, generatorActive, detectorActive;
  wire         txOverrideIdleInvert, decoderAmi, decoderAlgorithm, lineViolation, signalLoss;
  integer      seed = 32'ha51e, mismatches = 0, check_count = 0, updCount = 0, i, n0;
  logic [7:0]  mdl [0:63];
  logic [31:0] v;
  logic        noMarks = 0, rstnQ = 0, s3 = 0, expGen, expDet, expTx, expViol, expLoss;
  logic        lastM, lastV, tick, bpv, same, e1h;
  logic [3:0]  d1 = 0, d2 = 0;
  logic [7:0]  thQ = 0;
  integer      zr = 0;

  always #2 clk = ~clk;
  always @(posedge clk) begin
    {lineMark, linePolarity, lineBitStrobe, inSignature, slotBitIndex, slotSelected,
     frameBitStrobe, framingBitPos, signalingBitPos} <= 11'($random(seed)) & ~{noMarks, 10'h000};
    if (counterUpdate === 1'b1) updCount <= updCount + 1;
    rstnQ <= rstn;
    expGen <= mdl[15][1] ? (mdl[15][2] || !((signalingBitPos && !mdl[17][3]) ||
              (framingBitPos && !mdl[17][4]))) : slotSelected && !(mdl[15][4] && slotBitIndex == 3'h7);
    expDet <= mdl[15][0] || (slotSelected && !(mdl[15][3] && slotBitIndex == 3'h7));
    expTx <= mdl[15][1] && !mdl[15][2];
    thQ <= expTh(mdl[17][0], mdl[16][7], mdl[16][6:5]);
  end

  // ----
  // Line model
  // ----
  always @(posedge clk) begin
    if (!rstn) {d1, d2, s3} <= 9'h000;
    else {d1, d2, s3} <= {lineBitStrobe, lineMark, linePolarity, inSignature, d1, d2[3]};
    tick = d2[3] && !s3;
    bpv = d2[2] && d2[1] == lastM;
    same = bpv && d2[1] == lastV;
    e1h = mdl[17][0] && !mdl[16][7];
    if (!rstn || functionResetN !== 1'b1) begin
      {lastM, lastV, expViol, expLoss} = 4'h0;
      zr = 0;
    end else if (tick) begin
      expViol = (e1h && mdl[16][1]) ? same : bpv && (!d2[0] || (e1h && same));
      if (bpv) lastV = d2[1];
      if (d2[2]) begin
        lastM = d2[1];
        zr = 0;
        expLoss = 0;
      end else begin
        if (zr >= thQ) expLoss = 1;
        if (zr < 255) zr++;
      end
    end else expViol = 0;
  end

  always @(negedge clk) begin
    if (rstnQ && functionResetN === 1'b1) begin
      chkPort(generatorActive, expGen, "gen");
      chkPort(detectorActive, expDet, "det");
      chkPort(txOverrideIdleInvert, expTx, "tx override");
      chkPort(lineViolation, expViol, "violation");
      chkPort(signalLoss, expLoss, "loss");
    end
  end

  gcr_global_control DUT (.*);

  // ----
  // Model
  // ----
  function automatic logic mapped(logic [7:0] a);
    return a[7:2] == 6'h0A || (a[7:2] >= 6'h0C && a[7:2] <= 6'h12);
  endfunction
  function automatic logic [1:0] expResp(logic [7:0] a);
    return mapped(a) ? `GCR_RESP_OKAY : `GCR_RESP_SLVERR;
  endfunction
  function automatic logic [31:0] expRd(logic [7:0] a);
    if (!mapped(a)) return 32'h0;
    if (a[7:2] == 6'h0A) return mdl[17][2] ? 32'h0000_0040 : 32'h0;
    if (a[7:2] == 6'h0D) return {24'h0, `GCR_TYPE_CODE, `GCR_VERSION_CODE};
    return {24'h0, mdl[a[7:2]]};
  endfunction
  function automatic void mdlWr(logic [7:0] a, logic [7:0] d, logic [3:0] st);
    if (!mapped(a) || !st[0] || (mdl[14][0] && a[7:2] != 6'h0E)) return;
    case (a[7:2])
      6'h0C: mdl[12] = d & 8'h33;
      6'h0E: mdl[14] = d & 8'h01;
      6'h0F: mdl[15] = d;
      6'h10: mdl[16] = d & 8'hE7;
      6'h11: mdl[17] = d & 8'h1F;
      default: ;
    endcase
    if (mdl[17][1]) mdl[16] = 8'h00;
    if (mdl[14][0]) foreach (mdl[k]) if (k != 14) mdl[k] = 8'h00;
  endfunction
  function automatic logic [7:0] expTh(logic e1, logic ami, logic [1:0] c);
    if (c != 2'h0) return c == 2'h1 ? 8'h1F : c == 2'h2 ? 8'h3F : 8'hAF;
    return (e1 && !ami) ? 8'h0A : 8'h0F;
  endfunction

  // ----
  // Checks and bus tasks
  // ----
  task fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task wrap_up;
    $display("TB: checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chkData(input logic [31:0] g, e, input string m);
    check_count++;
    if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
  endtask
  task chkResp(input logic [1:0] g, e, input string m);
    check_count++;
    if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
  endtask
  task chkPort(input logic [7:0] g, e, input string m);
    check_count++;
    if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
  endtask
  function automatic logic sig(int k);
    return k == 0 ? s_axi_awready : k == 1 ? s_axi_bvalid : k == 2 ? s_axi_arready : s_axi_rvalid;
  endfunction
  task waitFor(input int k);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sig(k) !== 1'b1 && n < 50);
    if (sig(k) !== 1'b1) begin
      fail("wait limit");
      wrap_up;
    end
  endtask
  task axiWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    waitFor(0);
    @(posedge clk);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    waitFor(1);
    chkResp(s_axi_bresp, expResp(a), "write resp");
    mdlWr(a, d[7:0], st);
    @(posedge clk);
    s_axi_bready <= 1;
    @(posedge clk);
    s_axi_bready <= 0;
  endtask
  task rdChk(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    waitFor(2);
    @(posedge clk);
    s_axi_arvalid <= 0;
    waitFor(3);
    chkData(s_axi_rdata, expRd(a), $sformatf("read %h", a));
    chkResp(s_axi_rresp, expResp(a), "read resp");
    @(posedge clk);
    s_axi_rready <= 1;
    @(posedge clk);
    s_axi_rready <= 0;
  endtask
  task hwReset;
    @(posedge clk);
    rstn <= 0;
    repeat (8) @(posedge clk);
    rstn <= 1;
    foreach (mdl[k]) mdl[k] = 8'h00;
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    hwReset;
    for (i = 12; i <= 16; i++) rdChk(8'(i * 4));
    chkPort({linkPair3ClockOn, linkPair2ClockOn, linkPair1ClockOn, functionResetN}, 8'h0F, "on");
    noMarks <= 1;
    repeat (200) @(negedge clk);
    chkPort(signalLoss, 8'h01, "loss raised");
    noMarks <= 0;
    $display("test reset done");
    n0 = updCount;
    axiWr(8'h34, $random(seed), 4'hF);
    chkPort(8'(updCount - n0), 8'h01, "update pulses");
    rdChk(8'h34);
    $display("test identity done");
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      v[2:0] = i[2:0];
      axiWr(8'h44, (v >> 8) & 32'h0000_0019, 4'hF);
      axiWr(8'h3C, v, 4'hF);
      rdChk(8'h3C);
      chkPort({linkPair3ClockOn, linkPair2ClockOn, linkPair1ClockOn, generatorInReceivePath},
              {4'h0, ~v[7:5], v[2]}, "pattern outputs");
    end
    axiWr(8'h3C, 32'h0000_00FF, 4'h0);
    rdChk(8'h3C);
    $display("test pattern done");
    for (i = 0; i < 16; i++) begin
      v = $random(seed);
      axiWr(8'h44, {31'h0, i[3]}, 4'hF);
      v = {24'h0, i[2], i[1:0], 2'b00, v[1:0], 1'b0};
      axiWr(8'h40, v, 4'hF);
      rdChk(8'h40);
      chkPort(lossThreshold, expTh(i[3], i[2], i[1:0]), "threshold");
      chkPort({decoderAmi, decoderAlgorithm}, {6'h0, v[7], v[2]}, "decoder");
    end
    axiWr(8'h44, 32'h0000_0002, 4'hF);
    rdChk(8'h40);
    axiWr(8'h40, 32'h0000_0080, 4'hF);
    rdChk(8'h40);
    chkPort(decoderAmi, 8'h00, "single rail");
    $display("test decoder done");
    for (i = 0; i < 2; i++) begin
      axiWr(8'h44, 32'(i * 4), 4'hF);
      rdChk(8'h34);
      rdChk(8'h28);
    end
    axiWr(8'hFC, $random(seed), 4'hF);
    rdChk(8'h00);
    rdChk(8'hFC);
    $display("test revision and unmapped done");
    axiWr(8'h38, 32'h0000_0001, 4'hF);
    chkPort({linkPair3ClockOn, linkPair2ClockOn, linkPair1ClockOn, functionResetN}, 8'h00, "held");
    axiWr(8'h3C, 32'h0000_0000, 4'hF);
    rdChk(8'h3C);
    rdChk(8'h38);
    axiWr(8'h38, 32'h0000_0000, 4'hF);
    chkPort(functionResetN, 8'h01, "released");
    axiWr(8'h38, 32'h0000_0001, 4'hF);
    hwReset;
    rdChk(8'h38);
    chkPort(functionResetN, 8'h01, "hw cleared");
    $display("test soft reset done");
    wrap_up;
  end
endmodule

bind gcr_global_control gcr_props u_props (.*);
